// ===== hw/bspc_cfg.svh
`ifndef BSPC_CFG_SVH
`define BSPC_CFG_SVH
// What this block does
// - Code 10 without adapter enters ship mode
// - Button hold or adapter attach leaves ship
// - Ship exit restores register reset values
// - Ship entry needs adapter absent
// - Input-qualified: code 11 or button resets
// - Unqualified: reset only without input supply
// - Register reset delayed, button reset immediate
// - Reset cycles switch on, off, on
// - Battery undervoltage opens switch, recovery resets
// - Two overcurrent levels, 100 us, 50 ms
// - Overcurrent hiccup 100 ms off, 1% on
// - Input overvoltage stops converter, discharges input
// - System overvoltage stops switching, pulls down
// - High-side overcurrent ends current switching cycle
// - System short forces pulse frequency operation
// - Battery overvoltage opens switch, discharges battery
// - Sleep comparator stops switching, power-good high
// - Poor source gives battery-only, status 000
// - Thermal regulation cuts current, halves timer
// - Buck shutdown turns converter and switch off
// - Battery-only shutdown turns switch off
// - Flags latch until read, status tracks
// - Unmasked event gives 256 us low pulse
// - Switch-off delay 25 ms or 12.5 s

`define BSPC_CLK_MHZ 100
`define BSPC_PK_QUAL_US 100
`define BSPC_PK_QUAL_CYC (`BSPC_PK_QUAL_US * `BSPC_CLK_MHZ)
`define BSPC_SW_QUAL_MS 50
`define BSPC_SW_QUAL_CYC (`BSPC_SW_QUAL_MS * 1000 * `BSPC_CLK_MHZ)
`define BSPC_HIC_OFF_MS 100
`define BSPC_HIC_OFF_CYC (`BSPC_HIC_OFF_MS * 1000 * `BSPC_CLK_MHZ)
`define BSPC_HIC_ON_PCT 1
`define BSPC_HIC_ON_CYC (`BSPC_HIC_OFF_CYC / 100 * `BSPC_HIC_ON_PCT)
`define BSPC_INT_US 256
`define BSPC_INT_CYC (`BSPC_INT_US * `BSPC_CLK_MHZ)
`define BSPC_DLY_SHORT_MS 25
`define BSPC_DLY_SHORT_CYC (`BSPC_DLY_SHORT_MS * 1000 * `BSPC_CLK_MHZ)
`define BSPC_DLY_LONG_DS 125
`define BSPC_DLY_LONG_CYC (`BSPC_DLY_LONG_DS * 100000 * `BSPC_CLK_MHZ)
`define BSPC_SHIP_EXIT_MS 1
`define BSPC_SHIP_EXIT_CYC (`BSPC_SHIP_EXIT_MS * 1000 * `BSPC_CLK_MHZ)
`define BSPC_BTN_RST_MS 10
`define BSPC_BTN_RST_CYC (`BSPC_BTN_RST_MS * 1000 * `BSPC_CLK_MHZ)
`define BSPC_RST_OFF_MS 10
`define BSPC_RST_OFF_CYC (`BSPC_RST_OFF_MS * 1000 * `BSPC_CLK_MHZ)

`define BSPC_OFF_CTRL 8'h00
`define BSPC_OFF_STAT 8'h04
`define BSPC_OFF_FLAG 8'h08
`define BSPC_OFF_MASK 8'h0c
`define BSPC_CTRL_WV_BIT 2
`define BSPC_CTRL_DS_BIT 3
`define BSPC_MASK_RST 6'h00
`define BSPC_SRC_ADAPTER 3'h1
`define BSPC_F_IN 0
`define BSPC_F_BAT 1
`define BSPC_F_SOVP 2
`define BSPC_F_SHORT 3
`define BSPC_F_THERMAL_REGULATION_LIMIT 4
`define BSPC_F_TSHUT 5
`define BSPC_NFLG 6
`endif

// ===== hw/bspc_ctrl.sv
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`include "bspc_cfg.svh"
module bspc_ctrl import bspc_pkg::*; #(
  parameter logic [31:0] PK_QUAL_CYC   = `BSPC_PK_QUAL_CYC,
  parameter logic [31:0] SW_QUAL_CYC   = `BSPC_SW_QUAL_CYC,
  parameter logic [31:0] HIC_OFF_CYC   = `BSPC_HIC_OFF_CYC,
  parameter logic [31:0] HIC_ON_CYC    = `BSPC_HIC_ON_CYC,
  parameter logic [31:0] INT_CYC       = `BSPC_INT_CYC,
  parameter logic [31:0] DLY_SHORT_CYC = `BSPC_DLY_SHORT_CYC,
  parameter logic [31:0] DLY_LONG_CYC  = `BSPC_DLY_LONG_CYC,
  parameter logic [31:0] SHIP_EXIT_CYC = `BSPC_SHIP_EXIT_CYC,
  parameter logic [31:0] BTN_RST_CYC   = `BSPC_BTN_RST_CYC,
  parameter logic [31:0] RST_OFF_CYC   = `BSPC_RST_OFF_CYC
)(
  input  wire logic        CLK,             // Clock
  input  wire logic        RST_B,           // Async reset, low
  input  wire logic [7:0]  ADR_I,           // Bus byte address
  input  wire logic [31:0] DAT_I,           // Bus write data
  output logic      [31:0] DAT_O,           // Bus read data
  input  wire logic [3:0]  SEL_I,           // Byte enables
  input  wire logic        WE_I,            // Write strobe
  input  wire logic        CYC_I,           // Bus cycle
  input  wire logic        STB_I,           // Bus strobe
  output logic             ACK_O,           // Bus acknowledge
  input  wire logic        ADAPTER_PRESENT, // Input above UVLO
  input  wire logic        WAKE_BUTTON_N,   // Wake button, low
  input  wire logic        BAT_UV,          // Battery undervolt
  input  wire logic        BAT_PK_OC,       // Peak current trip
  input  wire logic        BAT_SW_OC,       // Switch OCP trip
  input  wire logic        INPUT_OVP,       // Input overvolt
  input  wire logic        SYS_OVP,         // System overvolt
  input  wire logic        HS_OC,           // High-side OCP
  input  wire logic        SW_CYC_START,    // Switching cycle
  input  wire logic        SYS_SHORT,       // System short
  input  wire logic        BAT_OVP,         // Battery overvolt
  input  wire logic        SLEEP_CMP,       // Input near battery
  input  wire logic        POOR_SOURCE,     // Poor source
  input  wire logic        TJ_REG,          // Above reg limit
  input  wire logic        TJ_SHUT,         // Above shutdown
  output logic             BATTERY_PATH_SWITCH_ON, // Switch on
  output logic             SERIAL_EN,       // Interface on
  output logic             CONVERTER_EN,    // Converter on
  output logic             HS_DRIVE_OFF,    // High-side off
  output logic             INPUT_DISCHARGE_EN, // Input sink
  output logic             SYS_PULLDOWN_EN, // System sink
  output logic             PULSE_FREQUENCY_OPERATION, // PULSE_FREQUENCY_OPERATION
  output logic             BAT_DISCHARGE_EN, // Battery sink
  output logic             POWER_GOOD_N,    // Power good, low
  output logic             CHARGE_CURRENT_REDUCE, // Cut current
  output logic             SAFETY_TIMER_HALF, // Half timer rate
  output logic             INT_N            // Interrupt, low
);
  // Sampled comparator inputs
  logic        a_pres;
  logic        btn;
  logic        bat_uv;
  logic        pk_oc;
  logic        sw_oc;
  logic        in_ovp;
  logic        s_ovp;
  logic        hs_oc;
  logic        s_short;
  logic        b_ovp;
  logic        sleep;
  logic        poor;
  logic        tj_reg;
  logic        tj_shut;
  logic [13:0] in_r;

  // Registers
  bspc_st_t    st_r;
  bspc_st_t    st_nxt;
  logic [31:0] tmr_r;
  logic [31:0] tmr_nxt;
  bspc_swc_t   code_r;
  logic        wv_r;
  logic        ds_r;
  logic [5:0]  mask_r;
  logic [5:0]  flag_r;
  logic [5:0]  flag_nxt;
  logic [5:0]  stat_d_r;
  logic [5:0]  rcap_r;
  logic [31:0] rdat_r;
  logic        ack_r;
  logic        oc_stat_r;
  logic        hs_off_r;
  logic        btn_q_d_r;
  logic [31:0] int_r;

  // Internal terms
  logic        buck;
  logic        sw_on;
  logic        ser_en;
  logic        pk_q;
  logic        sw_q;
  logic        oc_q;
  logic        btn_q;
  logic        btn_hit;
  logic        btn_go;
  logic        rst_ok;
  logic        exit_q;
  logic        regrst;
  logic        srst_end;
  logic [31:0] dly_cyc;
  logic [5:0]  stat;
  logic [5:0]  evt;
  logic [5:0]  clr;
  logic [2:0]  src;
  logic        req;
  logic        wr;
  logic        rd_end;
  logic [31:0] rd_mux;
  bspc_swc_t   wcode;

  // Word address match
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction : hit

  // Sample comparators once
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) in_r <= 14'h0;
    else in_r <= {TJ_SHUT, TJ_REG, POOR_SOURCE, SLEEP_CMP,
                  BAT_OVP, SYS_SHORT, HS_OC, SYS_OVP,
                  INPUT_OVP, BAT_SW_OC, BAT_PK_OC, BAT_UV,
                  !WAKE_BUTTON_N, ADAPTER_PRESENT};
  end

  // Named comparator levels
  assign a_pres  = in_r[0];
  assign btn     = in_r[1];
  assign bat_uv  = in_r[2];
  assign pk_oc   = in_r[3];
  assign sw_oc   = in_r[4];
  assign in_ovp  = in_r[5];
  assign s_ovp   = in_r[6];
  assign hs_oc   = in_r[7];
  assign s_short = in_r[8];
  assign b_ovp   = in_r[9];
  assign sleep   = in_r[10];
  assign poor    = in_r[11];
  assign tj_reg  = in_r[12];
  assign tj_shut = in_r[13];

  // Operating mode
  assign buck = a_pres && !poor;

  // Overcurrent qualification while switch on, then button hold qualification
  bspc_qual #(.CNT(PK_QUAL_CYC)) u_pk (
    .clk   (CLK),
    .rst_b (RST_B),
    .lvl   (pk_oc && sw_on),
    .done  (pk_q)
  );
  bspc_qual #(.CNT(SW_QUAL_CYC)) u_sw (
    .clk   (CLK),
    .rst_b (RST_B),
    .lvl   (sw_oc && sw_on),
    .done  (sw_q)
  );
  bspc_qual #(.CNT(BTN_RST_CYC)) u_btn (
    .clk   (CLK),
    .rst_b (RST_B),
    .lvl   (btn),
    .done  (btn_q)
  );
  bspc_qual #(.CNT(SHIP_EXIT_CYC)) u_exit (
    .clk   (CLK),
    .rst_b (RST_B),
    .lvl   (btn && st_r == BSPC_SHIP),
    .done  (exit_q)
  );

  // Sequencer triggers
  assign oc_q    = pk_q || sw_q;
  assign btn_hit = btn_q && !btn_q_d_r;
  assign rst_ok  = wv_r || !a_pres;
  assign btn_go  = btn_hit && rst_ok;
  assign dly_cyc = ds_r ? DLY_LONG_CYC : DLY_SHORT_CYC;

  // Switch sequencer next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      BSPC_NORM: begin
        if (!a_pres && bat_uv) st_nxt = BSPC_UVLO;
        else if (oc_q) st_nxt = BSPC_HOFF;
        else if (btn_go) st_nxt = BSPC_SRST;
        else if (code_r == BSPC_SW_SHIP ||
                 code_r == BSPC_SW_SRST) st_nxt = BSPC_DLY;
      end
      BSPC_DLY: begin
        if (code_r == BSPC_SW_NORM) st_nxt = BSPC_NORM;
        else if (!a_pres && bat_uv) st_nxt = BSPC_UVLO;
        else if (tmr_r >= dly_cyc - 32'h1) begin
          if (code_r == BSPC_SW_SRST) st_nxt = BSPC_SRST;
          else st_nxt = BSPC_SHIPW;
        end
      end
      BSPC_SHIPW: begin
        if (code_r == BSPC_SW_NORM) st_nxt = BSPC_NORM;
        else if (!a_pres) st_nxt = BSPC_SHIP;
      end
      BSPC_SHIP: begin
        if (exit_q || a_pres) st_nxt = BSPC_NORM;
      end
      BSPC_SRST: begin
        if (tmr_r >= RST_OFF_CYC - 32'h1) st_nxt = BSPC_NORM;
      end
      BSPC_HOFF: begin
        if (tmr_r >= HIC_OFF_CYC - 32'h1) st_nxt = BSPC_HON;
      end
      BSPC_HON: begin
        if (oc_q) st_nxt = BSPC_HOFF;
        else if (tmr_r >= HIC_ON_CYC - 32'h1) st_nxt = BSPC_NORM;
      end
      BSPC_UVLO: begin
        if (!bat_uv || a_pres) st_nxt = BSPC_NORM;
      end
      default: st_nxt = BSPC_NORM;
    endcase
  end

  // Timer restarts on every state change
  assign tmr_nxt = (st_nxt != st_r) ? 32'h0 : tmr_r + 32'h1;

  // Sequencer registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r      <= BSPC_NORM;
      tmr_r     <= 32'h0;
      btn_q_d_r <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      tmr_r     <= tmr_nxt;
      btn_q_d_r <= btn_q;
    end
  end

  // Leaving ship or undervoltage restores registers
  assign regrst = (st_r == BSPC_SHIP || st_r == BSPC_UVLO) &&
                  st_nxt == BSPC_NORM;
  assign srst_end = st_r == BSPC_SRST && st_nxt == BSPC_NORM;

  // Battery switch and interface enable
  assign sw_on = (st_r == BSPC_NORM || st_r == BSPC_DLY ||
                  st_r == BSPC_HON ||
                  (st_r == BSPC_SHIPW && !wv_r)) &&
                 !(b_ovp && buck) && !tj_shut;
  assign ser_en = !(st_r == BSPC_SHIP || st_r == BSPC_UVLO);

  // Status vector
  assign stat[`BSPC_F_IN]    = a_pres && (in_ovp || sleep);
  assign stat[`BSPC_F_BAT]   = oc_stat_r || (b_ovp && buck);
  assign stat[`BSPC_F_SOVP]  = s_ovp && buck;
  assign stat[`BSPC_F_SHORT] = s_short && buck;
  assign stat[`BSPC_F_THERMAL_REGULATION_LIMIT]  = tj_reg && buck;
  assign stat[`BSPC_F_TSHUT] = tj_shut;
  assign src = buck ? `BSPC_SRC_ADAPTER : 3'h0;
  assign evt = stat & ~stat_d_r;

  // Overcurrent status: set on trip, cleared once off
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) oc_stat_r <= 1'b0;
    else if (st_r != BSPC_HOFF && st_nxt == BSPC_HOFF)
      oc_stat_r <= 1'b1;
    else if (st_r == BSPC_HOFF) oc_stat_r <= 1'b0;
  end

  // High-side drive off for the rest of the cycle
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) hs_off_r <= 1'b0;
    else if (hs_oc && buck) hs_off_r <= 1'b1;
    else if (SW_CYC_START) hs_off_r <= 1'b0;
  end

  // Status history for event detection
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) stat_d_r <= 6'h0;
    else stat_d_r <= stat;
  end

  // Latched flags, set wins over read clear
  genvar i;
  generate
    for (i = 0; i < `BSPC_NFLG; i++) begin : g_flag
      assign flag_nxt[i] = evt[i] || (flag_r[i] && !clr[i]);
      always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) flag_r[i] <= 1'b0;
        else if (regrst) flag_r[i] <= 1'b0;
        else flag_r[i] <= flag_nxt[i];
      end
    end
  endgenerate

  // Interrupt pulse, masked events still flag
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) int_r <= 32'h0;
    else if (|(evt & ~mask_r)) int_r <= INT_CYC;
    else if (int_r != 32'h0) int_r <= int_r - 32'h1;
  end

  // Bus decode
  assign req    = CYC_I && STB_I;
  assign wr     = req && ack_r && WE_I && SEL_I[0] && ser_en;
  assign rd_end = req && ack_r && !WE_I && ser_en &&
                  hit(ADR_I, `BSPC_OFF_FLAG);
  assign clr    = rd_end ? rcap_r : 6'h0;
  assign wcode  = bspc_swc_t'(DAT_I[1:0]);

  // Read selection, zero when interface off or unmapped
  assign rd_mux =
    !ser_en ? 32'h0 :
    hit(ADR_I, `BSPC_OFF_CTRL) ?
      {28'h0, ds_r, wv_r, code_r} :
    hit(ADR_I, `BSPC_OFF_STAT) ?
      {13'h0, src, st_r, 2'h0, stat} :
    hit(ADR_I, `BSPC_OFF_FLAG) ? {26'h0, flag_r} :
    hit(ADR_I, `BSPC_OFF_MASK) ? {26'h0, mask_r} :
    32'h0;

  // Bus answer one cycle after request
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0;
      rcap_r <= 6'h0;
    end else begin
      ack_r <= req && !ack_r;
      if (req && !ack_r) begin
        rdat_r <= rd_mux;
        rcap_r <= rd_mux[5:0];
      end
    end
  end

  // Control register
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      code_r <= BSPC_SW_NORM;
      wv_r   <= 1'b0;
      ds_r   <= 1'b0;
    end else if (regrst) begin
      code_r <= BSPC_SW_NORM;
      wv_r   <= 1'b0;
      ds_r   <= 1'b0;
    end else if (wr && hit(ADR_I, `BSPC_OFF_CTRL)) begin
      wv_r <= DAT_I[`BSPC_CTRL_WV_BIT];
      ds_r <= DAT_I[`BSPC_CTRL_DS_BIT];
      if (wcode == BSPC_SW_SRST && a_pres &&
          !DAT_I[`BSPC_CTRL_WV_BIT])
        code_r <= BSPC_SW_NORM;
      else code_r <= wcode;
    end else if (srst_end) begin
      code_r <= BSPC_SW_NORM;
    end
  end

  // Mask register
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) mask_r <= `BSPC_MASK_RST;
    else if (regrst) mask_r <= `BSPC_MASK_RST;
    else if (wr && hit(ADR_I, `BSPC_OFF_MASK))
      mask_r <= DAT_I[5:0];
  end

  // Bus outputs
  assign ACK_O = ack_r;
  assign DAT_O = rdat_r;

  // Power stage controls
  assign BATTERY_PATH_SWITCH_ON = sw_on;
  assign SERIAL_EN    = ser_en;
  assign CONVERTER_EN = buck && !in_ovp && !s_ovp && !sleep &&
                        !tj_shut &&
                        !(st_r == BSPC_SRST && wv_r);
  assign HS_DRIVE_OFF = hs_off_r;
  assign INPUT_DISCHARGE_EN = a_pres && in_ovp;
  assign SYS_PULLDOWN_EN = stat[`BSPC_F_SOVP];
  assign PULSE_FREQUENCY_OPERATION = stat[`BSPC_F_SHORT];
  assign BAT_DISCHARGE_EN = b_ovp && buck;
  assign POWER_GOOD_N = !buck || sleep;
  assign CHARGE_CURRENT_REDUCE = stat[`BSPC_F_THERMAL_REGULATION_LIMIT];
  assign SAFETY_TIMER_HALF = stat[`BSPC_F_THERMAL_REGULATION_LIMIT];
  assign INT_N = (int_r == 32'h0);
endmodule : bspc_ctrl

// ===== hw/bspc_pkg.sv
package bspc_pkg;
  // Battery switch control codes
  typedef enum logic [1:0] {
    BSPC_SW_NORM = 2'h0,
    BSPC_SW_SHDN = 2'h1,
    BSPC_SW_SHIP = 2'h2,
    BSPC_SW_SRST = 2'h3
  } bspc_swc_t;
  // Switch sequencer states
  typedef enum logic [7:0] {
    BSPC_NORM  = 8'h01,
    BSPC_DLY   = 8'h02,
    BSPC_SHIPW = 8'h04,
    BSPC_SHIP  = 8'h08,
    BSPC_SRST  = 8'h10,
    BSPC_HOFF  = 8'h20,
    BSPC_HON   = 8'h40,
    BSPC_UVLO  = 8'h80
  } bspc_st_t;
endpackage : bspc_pkg

// ===== hw/bspc_qual.sv
`timescale 1ns/10ps
module bspc_qual #(
  parameter logic [31:0] CNT = 32'h0000_0001
)(
  input  wire logic clk,  // System clock
  input  wire logic rst_b, // Async reset, low
  input  wire logic lvl,  // Level to qualify
  output logic      done  // Level held CNT cycles
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;

  // Count while high, saturate at CNT
  assign cnt_nxt = !lvl ? 32'h0 :
                   (cnt_r == CNT) ? CNT : cnt_r + 32'h1;
  assign done    = lvl && (cnt_r == CNT);

  // Hold counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cnt_r <= 32'h0;
    else cnt_r <= cnt_nxt;
  end
endmodule : bspc_qual

// ===== testbench/bspc_ana_model.sv
`timescale 1ns/10ps
module bspc_ana_model (
  input  wire logic        CLK,           // Clock
  input  wire logic [12:0] cond,          // Wanted levels
  input  wire logic        btn_go,        // Start press
  input  wire logic [7:0]  btn_len,       // Press cycles
  output logic      [12:0] cmp,           // Comparator levels
  output logic             WAKE_BUTTON_N, // Button, low
  output logic             SW_CYC_START   // Cycle start
);
  logic [12:0] cmp_r = 13'h0;
  logic [7:0]  btn_r = 8'h00;
  logic [2:0]  ph_r  = 3'h0;
  // Levels settle a cycle after request
  always_ff @(posedge CLK) begin
    cmp_r <= cond;
    ph_r  <= ph_r + 3'h1;
  end
  // Button held low, then pulled up
  always_ff @(posedge CLK) begin
    if (btn_go) begin
      btn_r <= btn_len;
    end else if (btn_r != 8'h00) begin
      btn_r <= btn_r - 8'h01;
    end
  end
  // Outputs
  assign cmp           = cmp_r;
  assign WAKE_BUTTON_N = (btn_r == 8'h00);
  assign SW_CYC_START  = (ph_r == 3'h7);
endmodule : bspc_ana_model

// ===== testbench/bspc_ctrl_asserts.sv
`timescale 1ns/10ps
module bspc_ctrl_asserts (
  input wire logic CLK,                       // Clock
  input wire logic RST_B,                     // Reset
  input wire logic ADAPTER_PRESENT,           // Adapter
  input wire logic INPUT_OVP,                 // Input ovp
  input wire logic SYS_OVP,                   // Sys ovp
  input wire logic SYS_SHORT,                 // Short
  input wire logic BAT_OVP,                   // Bat ovp
  input wire logic SLEEP_CMP,                 // Sleep
  input wire logic POOR_SOURCE,               // Poor
  input wire logic TJ_REG,                    // Warm
  input wire logic TJ_SHUT,                   // Hot
  input wire logic BATTERY_PATH_SWITCH_ON,    // Switch
  input wire logic SERIAL_EN,                 // Bus on
  input wire logic CONVERTER_EN,              // Converter
  input wire logic INPUT_DISCHARGE_EN,        // Input sink
  input wire logic SYS_PULLDOWN_EN,           // Sys sink
  input wire logic PULSE_FREQUENCY_OPERATION, // Pulse mode
  input wire logic BAT_DISCHARGE_EN,          // Bat sink
  input wire logic POWER_GOOD_N,              // Good, low
  input wire logic CHARGE_CURRENT_REDUCE,     // Cut
  input wire logic SAFETY_TIMER_HALF,         // Half
  input wire logic INT_N                      // Irq, low
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // Buck mode qualifier
  wire buck = ADAPTER_PRESENT && !POOR_SOURCE;
  // Fault responses one cycle after the sampled level
  property p_in_ovp;
    INPUT_OVP [*2] |-> !CONVERTER_EN && INPUT_DISCHARGE_EN;
  endproperty
  a_in_ovp: assert property (p_in_ovp) else $error("input ovp reaction missing");
  property p_sys_ovp;
    (buck && SYS_OVP) [*2] |-> !CONVERTER_EN && SYS_PULLDOWN_EN;
  endproperty
  a_sys_ovp: assert property (p_sys_ovp) else $error("system ovp reaction missing");
  property p_short;
    (buck && SYS_SHORT) [*2] |-> PULSE_FREQUENCY_OPERATION;
  endproperty
  a_short: assert property (p_short) else $error("short reaction missing");
  property p_bat_ovp;
    (buck && BAT_OVP) [*2] |-> BAT_DISCHARGE_EN && !BATTERY_PATH_SWITCH_ON;
  endproperty
  a_bat_ovp: assert property (p_bat_ovp) else $error("battery ovp reaction missing");
  property p_thermal_regulation_limit;
    (buck && TJ_REG) [*2] |-> CHARGE_CURRENT_REDUCE && SAFETY_TIMER_HALF;
  endproperty
  a_thermal_regulation_limit: assert property (p_thermal_regulation_limit) else $error("thermal regulation missing");
  property p_tshut;
    TJ_SHUT [*2] |-> !BATTERY_PATH_SWITCH_ON;
  endproperty
  a_tshut: assert property (p_tshut) else $error("thermal shutdown missing");
  property p_pg;
    (ADAPTER_PRESENT && (SLEEP_CMP || POOR_SOURCE)) [*2] |-> POWER_GOOD_N && !CONVERTER_EN;
  endproperty
  a_pg: assert property (p_pg) else $error("power good not released");
  // Interrupt pulse stays low for a while
  property p_int;
    $fell(INT_N) |=> !INT_N [*8];
  endproperty
  a_int: assert property (p_int) else $error("interrupt pulse too short");
  // Disabled bus goes with an open switch
  property p_ship;
    !SERIAL_EN |-> !BATTERY_PATH_SWITCH_ON;
  endproperty
  a_ship: assert property (p_ship) else $error("bus off with switch closed");
endmodule : bspc_ctrl_asserts
bind bspc_ctrl bspc_ctrl_asserts u_bspc_ctrl_asserts (.*);

// ===== testbench/tb.sv
`timescale 1ns/10ps
`include "bspc_cfg.svh"
module tb;
  logic CLK = 1'b0, RST_B, WE_I, CYC_I, STB_I, btn_go;
  logic [7:0]  ADR_I, btn_len;
  logic [31:0] DAT_I, DAT_O, q;
  logic [3:0]  SEL_I;
  logic [12:0] cond, cmp;
  logic ACK_O, ADAPTER_PRESENT, WAKE_BUTTON_N, BAT_UV, BAT_PK_OC, BAT_SW_OC, INPUT_OVP, SYS_OVP, HS_OC;
  logic SW_CYC_START, SYS_SHORT, BAT_OVP, SLEEP_CMP, POOR_SOURCE, TJ_REG, TJ_SHUT, BATTERY_PATH_SWITCH_ON;
  logic SERIAL_EN, CONVERTER_EN, HS_DRIVE_OFF, INPUT_DISCHARGE_EN, SYS_PULLDOWN_EN, PULSE_FREQUENCY_OPERATION;
  logic BAT_DISCHARGE_EN, POWER_GOOD_N, CHARGE_CURRENT_REDUCE, SAFETY_TIMER_HALF, INT_N;
  int   n_mismatch = 0, n_compared = 0;
  // Clock and comparator split
  always #5 CLK = ~CLK;
  assign {TJ_SHUT, TJ_REG, POOR_SOURCE, SLEEP_CMP, BAT_OVP, SYS_SHORT, HS_OC, SYS_OVP, INPUT_OVP, BAT_SW_OC,
          BAT_PK_OC, BAT_UV, ADAPTER_PRESENT} = cmp;
  bspc_ctrl #(.PK_QUAL_CYC(32'h14), .SW_QUAL_CYC(32'h32), .HIC_OFF_CYC(32'h64), .HIC_ON_CYC(32'ha),
    .INT_CYC(32'h10), .DLY_SHORT_CYC(32'h1e), .DLY_LONG_CYC(32'h3c), .SHIP_EXIT_CYC(32'h14),
    .BTN_RST_CYC(32'h28), .RST_OFF_CYC(32'h19)) u_bspc_ctrl (.*);
  bspc_ana_model u_bspc_ana_model (.*);
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask : chk1
  // One classic cycle, held until ack
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    ADR_I <= a;
    WE_I <= w;
    DAT_I <= d;
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    @(posedge CLK);
    while (ACK_O !== 1'b1 && n < 20) begin
      @(posedge CLK);
      n++;
    end
    chk1(ACK_O, 1'b1);
    q = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(a, 1'b0, 32'h0);
    chk32(q & m, e);
  endtask : rd
  task automatic drv(input logic [12:0] c);
    @(posedge CLK);
    cond <= c;
  endtask : drv
  task automatic press(input logic [7:0] n);
    @(posedge CLK);
    btn_len <= n;
    btn_go <= 1'b1;
    @(posedge CLK);
    btn_go <= 1'b0;
  endtask : press
  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  // Watchdog
  initial begin
    repeat (20000) @(posedge CLK);
    n_mismatch++;
    finish_test;
  end
  // Test sequence
  initial begin : main
    int idx [7] = '{4, 8, 5, 7, 11, 12, 9};
    int fl [7] = '{0, 1, 2, 3, 4, 5, 0};
    // Reset asserted, bus idle, button released, comparators low
    {RST_B, WE_I, CYC_I, STB_I, btn_go} <= 5'h0;
    {ADR_I, btn_len, DAT_I, SEL_I, cond} <= {8'h00, 8'h00, 32'h0, 4'hf, 13'h0};
    repeat (4) @(posedge CLK);
    RST_B <= 1'b1;
    rd(`BSPC_OFF_CTRL, 32'h0, 32'hffffffff);
    rd(`BSPC_OFF_STAT, 32'h100, 32'hffffffff);
    rd(8'h10, 32'h0, 32'hffffffff);
    // Write without the low byte enable is ignored
    SEL_I <= 4'he;
    bus(`BSPC_OFF_CTRL, 1'b1, 32'h8);
    SEL_I <= 4'hf;
    rd(`BSPC_OFF_CTRL, 32'h0, 32'hffffffff);
    drv(13'h1);
    repeat (20) @(posedge CLK);
    bus(`BSPC_OFF_FLAG, 1'b0, 32'h0);
    $display("test reset done");
    // Each fault: status, flag, read clear, pulse
    for (int i = 0; i < 7; i++) begin
      drv(13'h1 | (13'h1 << idx[i]));
      repeat (5) @(posedge CLK);
      chk1(INT_N, 1'b0);
      rd(`BSPC_OFF_STAT, 32'h1 << fl[i], 32'h3f);
      drv(13'h1);
      repeat (5) @(posedge CLK);
      rd(`BSPC_OFF_STAT, 32'h0, 32'h3f);
      rd(`BSPC_OFF_FLAG, 32'h1 << fl[i], 32'h3f);
      rd(`BSPC_OFF_FLAG, 32'h0, 32'h3f);
      repeat (20) @(posedge CLK);
      chk1(INT_N, 1'b1);
    end
    bus(`BSPC_OFF_MASK, 1'b1, 32'h10);
    drv(13'h801);
    repeat (5) @(posedge CLK);
    chk1(INT_N, 1'b1);
    drv(13'h41);
    repeat (4) @(posedge CLK);
    chk1(HS_DRIVE_OFF, 1'b1);
    drv(13'h1);
    repeat (12) @(posedge CLK);
    chk1(HS_DRIVE_OFF, 1'b0);
    rd(`BSPC_OFF_FLAG, 32'h10, 32'h10);
    rd(`BSPC_OFF_STAT, 32'h10000, 32'h70000);
    drv(13'h401);
    repeat (5) @(posedge CLK);
    rd(`BSPC_OFF_STAT, 32'h0, 32'h70000);
    $display("test faults done");
    // Two overcurrent levels and hiccup
    for (int j = 0; j < 2; j++) begin
      drv(13'h4 << j);
      repeat (j ? 42 : 12) @(posedge CLK);
      chk1(BATTERY_PATH_SWITCH_ON, 1'b1);
      repeat (20) @(posedge CLK);
      chk1(BATTERY_PATH_SWITCH_ON, 1'b0);
      drv(13'h0);
      repeat (50) @(posedge CLK);
      chk1(BATTERY_PATH_SWITCH_ON, 1'b0);
      repeat (70) @(posedge CLK);
      chk1(BATTERY_PATH_SWITCH_ON, 1'b1);
      rd(`BSPC_OFF_FLAG, 32'h2, 32'h2);
    end
    $display("test overcurrent done");
    // Ship mode, button exit, then with adapter
    bus(`BSPC_OFF_MASK, 1'b1, 32'h3f);
    bus(`BSPC_OFF_CTRL, 1'b1, 32'h2);
    repeat (20) @(posedge CLK);
    chk1(BATTERY_PATH_SWITCH_ON, 1'b1);
    repeat (30) @(posedge CLK);
    chk1(SERIAL_EN, 1'b0);
    press(8'h1e);
    repeat (40) @(posedge CLK);
    chk1(SERIAL_EN, 1'b1);
    rd(`BSPC_OFF_MASK, 32'h0, 32'h3f);
    drv(13'h1);
    bus(`BSPC_OFF_MASK, 1'b1, 32'h3f);
    bus(`BSPC_OFF_CTRL, 1'b1, 32'h2);
    repeat (50) @(posedge CLK);
    chk1(BATTERY_PATH_SWITCH_ON, 1'b1);
    drv(13'h0);
    repeat (5) @(posedge CLK);
    chk1(SERIAL_EN, 1'b0);
    drv(13'h1);
    repeat (5) @(posedge CLK);
    chk1(SERIAL_EN, 1'b1);
    rd(`BSPC_OFF_MASK, 32'h0, 32'h3f);
    $display("test ship done");
    // System reset by code, short then long delay
    drv(13'h0);
    bus(`BSPC_OFF_CTRL, 1'b1, 32'h7);
    repeat (20) @(posedge CLK);
    chk1(BATTERY_PATH_SWITCH_ON, 1'b1);
    repeat (15) @(posedge CLK);
    chk1(BATTERY_PATH_SWITCH_ON, 1'b0);
    repeat (30) @(posedge CLK);
    chk1(BATTERY_PATH_SWITCH_ON, 1'b1);
    rd(`BSPC_OFF_CTRL, 32'h4, 32'h7);
    bus(`BSPC_OFF_CTRL, 1'b1, 32'hb);
    repeat (45) @(posedge CLK);
    chk1(BATTERY_PATH_SWITCH_ON, 1'b1);
    repeat (30) @(posedge CLK);
    chk1(BATTERY_PATH_SWITCH_ON, 1'b0);
    repeat (30) @(posedge CLK);
    drv(13'h1);
    bus(`BSPC_OFF_CTRL, 1'b1, 32'h3);
    rd(`BSPC_OFF_CTRL, 32'h0, 32'h3);
    repeat (40) @(posedge CLK);
    chk1(BATTERY_PATH_SWITCH_ON, 1'b1);
    // Button reset without and with adapter
    for (int a = 0; a < 2; a++) begin
      drv({12'h0, a[0]});
      press(8'h3c);
      repeat (46) @(posedge CLK);
      chk1(BATTERY_PATH_SWITCH_ON, a[0]);
      repeat (70) @(posedge CLK);
    end
    $display("test reset paths done");
    // Battery undervoltage and recovery
    drv(13'h0);
    bus(`BSPC_OFF_MASK, 1'b1, 32'h3f);
    drv(13'h2);
    repeat (5) @(posedge CLK);
    chk1(SERIAL_EN, 1'b0);
    drv(13'h0);
    repeat (5) @(posedge CLK);
    chk1(SERIAL_EN, 1'b1);
    rd(`BSPC_OFF_MASK, 32'h0, 32'h3f);
    $display("test undervoltage done");
    finish_test;
  end
endmodule : tb
